// [aws_period_timer.sv]
`timescale 1ns/1ps
module aws_period_timer (
  // Clock, reset and enable.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Control from the sequencer.
  aws_timer_if.tmr tif
);

  logic [aws_pkg::CNT_W-1:0] setup_q;
  logic [aws_pkg::CNT_W-1:0] strobe_q;
  logic [aws_pkg::CNT_W-1:0] hold_q;
  logic [aws_pkg::CNT_W-1:0] cnt_q;
  logic [aws_pkg::CNT_W-1:0] sel_setup;
  logic [aws_pkg::CNT_W-1:0] sel_strobe;
  logic [aws_pkg::CNT_W-1:0] sel_hold;

  // Values are latched once per request so later narrow cycles reuse them.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      setup_q <= '0;
      strobe_q <= '0;
      hold_q <= '0;
    end
    else if (ce_in && tif.load)
    begin
      setup_q <= tif.setup_val; // R7
      strobe_q <= tif.strobe_val;
      hold_q <= tif.hold_val;
    end
  end

  // A load in the same cycle as a start must win over stale latched values.
  assign sel_setup = tif.load ? tif.setup_val : setup_q;
  assign sel_strobe = tif.load ? tif.strobe_val : strobe_q;
  assign sel_hold = tif.load ? tif.hold_val : hold_q;

  // Down counter; a period of value N lasts N+1 cycles.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (tif.start)
      begin
        case (tif.phase)
          aws_pkg::PH_SETUP: cnt_q <= sel_setup; // R15
          aws_pkg::PH_STROBE: cnt_q <= sel_strobe;
          default: cnt_q <= sel_hold;
        endcase
      end
      else if (cnt_q != '0)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // The current period ends in the cycle where the count reaches zero.
  assign tif.done = (cnt_q == '0);

endmodule : aws_period_timer

// [aws_pkg.sv]
// Notes on behaviour
// R1: Output enable stays high through every part of every write.
// R2: Requests wider than the external bus are sent as several external cycles.
// R3: An accepted request spends its turnaround interval, then enters setup.
// R4: Turnaround length comes from the addressed space's turnaround field.
// R5: A write directly after a write to the same space gets no turnaround.
// R6: In that same case with a zero turnaround field, one turnaround cycle is inserted.
// R7: Setup start loads setup, strobe and hold counts from the addressed space.
// R8: Setup start drives address, bank address and write data onto the pins.
// R9: Setup start drives the direction pin low unless it is already low.
// R10: Strobe start drives chip select and write strobe low together.
// R11: Hold start drives chip select and write strobe high.
// R12: Hold end releases address and data; direction rises only after the last cycle.
// R13: Further cycles of a wide request re-enter setup without turnaround or reload.
// R14: After completion return to idle, or go straight into a pending request's turnaround.
// R15: Strobes stay high in turnaround and setup; periods last their count plus one.
package aws_pkg;

  // Field layout of one space configuration word.
  localparam int CFG_W = 16;
  localparam int SETUP_LSB = 0;
  localparam int SETUP_W = 4;
  localparam int STROBE_LSB = 4;
  localparam int STROBE_W = 6;
  localparam int HOLD_LSB = 10;
  localparam int HOLD_W = 3;
  localparam int TURNAROUND_LSB = 13;
  localparam int TURNAROUND_W = 2;
  localparam int WIDTH16_BIT = 15;

  // Counter width wide enough for the largest period field.
  localparam int CNT_W = 6;

  // Lane widths of the two supported external bus sizes.
  localparam int LANE8_W = 8;
  localparam int LANE16_W = 16;

  // Pin level after reset and between cycles, and the one-cycle turnaround value.
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [1:0] TURNAROUND_ONE = 2'h1;

  typedef enum logic [1:0] {
    PH_SETUP,
    PH_STROBE,
    PH_HOLD
  } aws_phase_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TURN,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } aws_state_t;

endpackage : aws_pkg

// [aws_sram_model.sv]
`timescale 1ns/1ps
// Write-only asynchronous memory on the far side of the pins.
module aws_sram_model #(
  parameter int NUM_CS = 4,
  parameter int ADDR_W = 22
) (
  // Memory pins.
  input wire logic clk_in,
  input wire logic [NUM_CS-1:0] chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [ADDR_W-1:0] ext_address_in,
  input wire logic [aws_pkg::LANE16_W-1:0] ext_data_in
);
  logic [aws_pkg::LANE16_W-1:0] mem [int];
  // Latches at mid-cycle while selected; the pins hold through strobe, like an edge latch.
  always @(negedge clk_in)
  begin
    if (!write_strobe_n_in && !(&chip_select_n_in))
    begin
      mem[int'(ext_address_in)] = ext_data_in;
    end
  end
endmodule : aws_sram_model

// [aws_timer_if.sv]
`timescale 1ns/1ps
// Carries the period timing values and control between sequencer and timer.
interface aws_timer_if;
  logic load;
  logic start;
  aws_pkg::aws_phase_t phase;
  logic [aws_pkg::CNT_W-1:0] setup_val;
  logic [aws_pkg::CNT_W-1:0] strobe_val;
  logic [aws_pkg::CNT_W-1:0] hold_val;
  logic done;

  modport ctl (
    output load,
    output start,
    output phase,
    output setup_val,
    output strobe_val,
    output hold_val,
    input done
  );

  modport tmr (
    input load,
    input start,
    input phase,
    input setup_val,
    input strobe_val,
    input hold_val,
    output done
  );
endinterface : aws_timer_if

// [aws_write_sequencer.sv]
`timescale 1ns/1ps
module aws_write_sequencer #(
  parameter int NUM_CS = 4,
  parameter int DATA_W = 32,
  parameter int ADDR_W = 22,
  parameter int BANK_W = 2
) (
  // Clock, reset and enable.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Write request from on-chip requesters.
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [$clog2(NUM_CS)-1:0] req_cs_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [BANK_W-1:0] req_bank_in,
  input wire logic [DATA_W-1:0] req_data_in,
  // Per-space configuration words, space 0 in the low bits.
  input wire logic [NUM_CS*aws_pkg::CFG_W-1:0] space_config_reg_in,
  // Status.
  output logic busy_out,
  output logic done_out,
  // External memory pins.
  output logic [NUM_CS-1:0] chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out,
  output logic rd_wr_direction_out,
  output logic [ADDR_W-1:0] ext_address_out,
  output logic [BANK_W-1:0] ext_bank_address_out,
  output logic [aws_pkg::LANE16_W-1:0] ext_data_out,
  output logic ext_data_oe_out
);

  localparam int CS_W = $clog2(NUM_CS);
  localparam int BEAT_W = $clog2(DATA_W / aws_pkg::LANE8_W);

  // The data must split into whole 16-bit beats, and at least two spaces exist.
  if ((DATA_W % aws_pkg::LANE16_W) != 0 || NUM_CS < 2 || DATA_W < aws_pkg::LANE16_W)
  begin : g_param_check
    $error("aws_write_sequencer: unsupported parameter values");
  end

  // Pulls one space's configuration word out of the flat vector.
  function automatic logic [aws_pkg::CFG_W-1:0] cfg_of(
    input logic [NUM_CS*aws_pkg::CFG_W-1:0] all,
    input logic [CS_W-1:0] cs
  );
    cfg_of = all[cs*aws_pkg::CFG_W +: aws_pkg::CFG_W];
  endfunction : cfg_of

  // Picks the lane slice of the request data for one beat.
  function automatic logic [aws_pkg::LANE16_W-1:0] beat_slice(
    input logic [DATA_W-1:0] data,
    input logic [BEAT_W-1:0] beat,
    input logic wide
  );
    logic [DATA_W-1:0] shifted;
    shifted = '0;
    if (wide)
    begin
      shifted = data >> (beat * aws_pkg::LANE16_W);
      beat_slice = shifted[aws_pkg::LANE16_W-1:0];
    end
    else
    begin
      shifted = data >> (beat * aws_pkg::LANE8_W);
      beat_slice = {{(aws_pkg::LANE16_W - aws_pkg::LANE8_W){1'b0}},
                    shifted[aws_pkg::LANE8_W-1:0]};
    end
  endfunction : beat_slice

  aws_timer_if tif ();

  aws_period_timer u_timer (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .tif(tif)
  );

  aws_pkg::aws_state_t state_q;
  aws_pkg::aws_state_t state_d;
  logic [CS_W-1:0] cs_q;
  logic [ADDR_W-1:0] addr_q;
  logic [BANK_W-1:0] bank_q;
  logic [DATA_W-1:0] data_q;
  logic wide_q;
  logic [BEAT_W-1:0] beat_q;
  logic [aws_pkg::TURNAROUND_W-1:0] turn_q;
  logic prev_wr_q;
  logic [aws_pkg::CFG_W-1:0] cfg_new;
  logic [aws_pkg::CFG_W-1:0] cfg_sel;
  logic [aws_pkg::TURNAROUND_W-1:0] turnaround_cycles;
  logic [aws_pkg::TURNAROUND_W-1:0] turn_need;
  logic back_to_back;
  logic last_beat;
  logic finishing;
  logic accept;
  logic enter_setup;
  logic [BEAT_W-1:0] beats_m1;
  logic [BEAT_W-1:0] beat_next;

  // A request is taken when idle, or in the final hold cycle of the last beat.
  assign beats_m1 = wide_q ? BEAT_W'(DATA_W / aws_pkg::LANE16_W - 1)
                           : BEAT_W'(DATA_W / aws_pkg::LANE8_W - 1);
  assign last_beat = (beat_q == beats_m1);
  assign finishing = (state_q == aws_pkg::ST_HOLD) && tif.done && last_beat;
  assign req_ready_out = (state_q == aws_pkg::ST_IDLE) || finishing; // R14
  assign accept = ce_in && req_valid_in && req_ready_out;

  // Turnaround need; exception cases are kept exactly as the device behaves.
  assign cfg_new = cfg_of(space_config_reg_in, req_cs_in);
  assign turnaround_cycles = cfg_new[aws_pkg::TURNAROUND_LSB +: aws_pkg::TURNAROUND_W]; // R4
  assign back_to_back = ((state_q == aws_pkg::ST_HOLD) || prev_wr_q) && (req_cs_in == cs_q);
  always_comb
  begin
    if (back_to_back && turnaround_cycles == '0)
    begin
      turn_need = aws_pkg::TURNAROUND_ONE; // R6
    end
    else if (back_to_back)
    begin
      turn_need = '0; // R5
    end
    else
    begin
      turn_need = turnaround_cycles; // R4
    end
  end

  // Setup entry from a fresh request uses the incoming space, else the held one.
  assign cfg_sel = accept ? cfg_new : cfg_of(space_config_reg_in, cs_q);
  assign enter_setup = (accept && turn_need == '0)
                       || (ce_in && state_q == aws_pkg::ST_TURN && turn_q == '0);

  // Timer control: fields load only at the first setup of a request.
  always_comb
  begin
    tif.load = enter_setup; // R7
    tif.start = 1'b0;
    tif.phase = aws_pkg::PH_SETUP;
    tif.setup_val = aws_pkg::CNT_W'(cfg_sel[aws_pkg::SETUP_LSB +: aws_pkg::SETUP_W]);
    tif.strobe_val = aws_pkg::CNT_W'(cfg_sel[aws_pkg::STROBE_LSB +: aws_pkg::STROBE_W]);
    tif.hold_val = aws_pkg::CNT_W'(cfg_sel[aws_pkg::HOLD_LSB +: aws_pkg::HOLD_W]);
    if (enter_setup)
    begin
      tif.start = 1'b1;
    end
    else if (state_q == aws_pkg::ST_SETUP && tif.done)
    begin
      tif.start = 1'b1;
      tif.phase = aws_pkg::PH_STROBE;
    end
    else if (state_q == aws_pkg::ST_STROBE && tif.done)
    begin
      tif.start = 1'b1;
      tif.phase = aws_pkg::PH_HOLD;
    end
    else if (state_q == aws_pkg::ST_HOLD && tif.done && !last_beat)
    begin
      tif.start = 1'b1; // R13
    end
  end

  // Next state of the sequencer.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      aws_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          state_d = enter_setup ? aws_pkg::ST_SETUP : aws_pkg::ST_TURN; // R3
        end
      end
      aws_pkg::ST_TURN:
      begin
        if (turn_q == '0)
        begin
          state_d = aws_pkg::ST_SETUP; // R3
        end
      end
      aws_pkg::ST_SETUP:
      begin
        if (tif.done)
        begin
          state_d = aws_pkg::ST_STROBE;
        end
      end
      aws_pkg::ST_STROBE:
      begin
        if (tif.done)
        begin
          state_d = aws_pkg::ST_HOLD;
        end
      end
      aws_pkg::ST_HOLD:
      begin
        if (tif.done && !last_beat)
        begin
          state_d = aws_pkg::ST_SETUP; // R13
        end
        else if (accept)
        begin
          state_d = enter_setup ? aws_pkg::ST_SETUP : aws_pkg::ST_TURN; // R14
        end
        else if (tif.done)
        begin
          state_d = aws_pkg::ST_IDLE; // R14
        end
      end
      default: state_d = aws_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= aws_pkg::ST_IDLE;
    end
    else if (ce_in)
    begin
      state_q <= state_d;
    end
  end

  // Request capture; the beat index restarts with each new request.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cs_q <= '0;
      addr_q <= '0;
      bank_q <= '0;
      data_q <= '0;
      wide_q <= 1'b0;
      turn_q <= '0;
    end
    else if (accept)
    begin
      cs_q <= req_cs_in;
      addr_q <= req_addr_in;
      bank_q <= req_bank_in;
      data_q <= req_data_in;
      wide_q <= cfg_new[aws_pkg::WIDTH16_BIT];
      turn_q <= turn_need - 1'b1;
    end
    else if (ce_in && state_q == aws_pkg::ST_TURN && turn_q != '0)
    begin
      turn_q <= turn_q - 1'b1; // R3
    end
  end

  // Beat counter steps after each hold that is not the last one.
  assign beat_next = (state_q == aws_pkg::ST_HOLD && tif.done && !last_beat)
                     ? beat_q + 1'b1 : beat_q;
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      beat_q <= '0;
    end
    else if (accept)
    begin
      beat_q <= '0;
    end
    else if (ce_in)
    begin
      beat_q <= beat_next; // R2
    end
  end

  // Remembers that the previous operation was a write, for one idle cycle.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      prev_wr_q <= 1'b0;
    end
    else if (ce_in)
    begin
      prev_wr_q <= finishing && !accept; // R5
    end
  end

  // Strobe pins: high in turnaround and setup, low only through strobe.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      chip_select_n_out <= {NUM_CS{aws_pkg::PIN_IDLE}};
      write_strobe_n_out <= aws_pkg::PIN_IDLE;
    end
    else if (ce_in)
    begin
      chip_select_n_out <= {NUM_CS{aws_pkg::PIN_IDLE}}; // R11 R15
      write_strobe_n_out <= aws_pkg::PIN_IDLE;
      if (state_d == aws_pkg::ST_STROBE)
      begin
        chip_select_n_out[cs_q] <= 1'b0; // R10
        write_strobe_n_out <= 1'b0;
      end
    end
  end

  // Address, bank and data are valid from setup start to hold end.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ext_address_out <= '0;
      ext_bank_address_out <= '0;
      ext_data_out <= '0;
      ext_data_oe_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (enter_setup && accept)
      begin
        ext_address_out <= req_addr_in; // R8
        ext_bank_address_out <= req_bank_in;
        ext_data_out <= beat_slice(req_data_in, '0, cfg_new[aws_pkg::WIDTH16_BIT]);
        ext_data_oe_out <= 1'b1;
      end
      else if (state_d == aws_pkg::ST_SETUP && state_q != aws_pkg::ST_SETUP)
      begin
        ext_address_out <= addr_q + ADDR_W'(beat_next); // R8 R13
        ext_bank_address_out <= bank_q;
        ext_data_out <= beat_slice(data_q, beat_next, wide_q);
        ext_data_oe_out <= 1'b1;
      end
      else if (state_q == aws_pkg::ST_HOLD && tif.done)
      begin
        ext_address_out <= '0; // R12
        ext_bank_address_out <= '0;
        ext_data_out <= '0;
        ext_data_oe_out <= 1'b0;
      end
    end
  end

  // Direction falls at setup start and rises only once the request is done.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rd_wr_direction_out <= aws_pkg::PIN_IDLE;
    end
    else if (ce_in)
    begin
      if (enter_setup)
      begin
        rd_wr_direction_out <= 1'b0; // R9
      end
      else if (finishing)
      begin
        rd_wr_direction_out <= aws_pkg::PIN_IDLE; // R12
      end
    end
  end

  // One-cycle completion pulse, registered so it lines up with the pins.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= finishing;
    end
  end

  // This block only writes, so the read enable never leaves its idle level.
  assign output_enable_n_out = aws_pkg::PIN_IDLE; // R1
  assign busy_out = (state_q != aws_pkg::ST_IDLE);

endmodule : aws_write_sequencer

// [aws_write_sequencer_props.sv]
`timescale 1ns/1ps
// Pin-level checks on the write sequencer, seen only from its ports.
module aws_write_sequencer_props #(
  parameter int NUM_CS = 4,
  parameter int ADDR_W = 22
) (
  // Clock and request side.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  // Status and memory pins.
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [NUM_CS-1:0] chip_select_n_out,
  input wire logic write_strobe_n_out,
  input wire logic output_enable_n_out,
  input wire logic rd_wr_direction_out,
  input wire logic [ADDR_W-1:0] ext_address_out,
  input wire logic [aws_pkg::LANE16_W-1:0] ext_data_out,
  input wire logic ext_data_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // The two edges of a strobe period.
  sequence s_strobe_start;
    $fell(write_strobe_n_out);
  endsequence
  sequence s_strobe_end;
    $rose(write_strobe_n_out);
  endsequence

  // One label per pin relation; the strobe-edge ones rely on the named sequences.
  a_oe_stays_high: assert property (output_enable_n_out)
    else $error("output enable went low");
  a_cs_we_pair: assert property (write_strobe_n_out == (&chip_select_n_out))
    else $error("select and write strobe differ");
  a_one_space: assert property ($onehot0(~chip_select_n_out))
    else $error("more than one select low");
  a_setup_first: assert property (s_strobe_start |-> $past(ext_data_oe_out) &&
    ext_data_oe_out && !rd_wr_direction_out)
    else $error("strobe began without a setup cycle");
  a_strobe_stable: assert property (!write_strobe_n_out && !$past(write_strobe_n_out)
    |-> $stable(ext_address_out) && $stable(ext_data_out))
    else $error("address or data moved during strobe");
  a_hold_valid: assert property (s_strobe_end |-> ext_data_oe_out && !rd_wr_direction_out)
    else $error("hold began without valid data");
  a_idle_quiet: assert property (!busy_out |-> rd_wr_direction_out && !ext_data_oe_out
    && ext_address_out == '0)
    else $error("pins not released while idle");
  a_take_starts: assert property (ce_in && req_valid_in && req_ready_out && !busy_out
    |=> busy_out)
    else $error("accepted request did not start");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_release_after: assert property ($fell(ext_data_oe_out) |-> $past(write_strobe_n_out)
    && ext_data_out == '0)
    else $error("data not cleared at release");
endmodule : aws_write_sequencer_props

bind aws_write_sequencer aws_write_sequencer_props #(.NUM_CS(NUM_CS), .ADDR_W(ADDR_W)) u_props (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out), .busy_out(busy_out), .done_out(done_out),
  .chip_select_n_out(chip_select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .output_enable_n_out(output_enable_n_out), .rd_wr_direction_out(rd_wr_direction_out),
  .ext_address_out(ext_address_out), .ext_data_out(ext_data_out),
  .ext_data_oe_out(ext_data_oe_out)
);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rstn;
  logic ce;
  logic req_valid;
  logic [1:0] req_cs;
  logic [21:0] req_addr;
  logic [1:0] req_bank;
  logic [31:0] req_data;
  logic [63:0] cfg;
  logic req_ready, busy, done, we_n, oe_n, rw, data_oe;
  logic [3:0] cs_n;
  logic [21:0] ext_addr;
  logic [1:0] ext_bank;
  logic [15:0] ext_data;
  int mismatches = 0;
  int checks_done = 0;

  aws_write_sequencer uut (
    .core_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_cs_in(req_cs), .req_addr_in(req_addr),
    .req_bank_in(req_bank), .req_data_in(req_data), .space_config_reg_in(cfg),
    .busy_out(busy), .done_out(done), .chip_select_n_out(cs_n), .write_strobe_n_out(we_n),
    .output_enable_n_out(oe_n), .rd_wr_direction_out(rw), .ext_address_out(ext_addr),
    .ext_bank_address_out(ext_bank), .ext_data_out(ext_data), .ext_data_oe_out(data_oe)
  );
  aws_sram_model u_mem (
    .clk_in(clk), .chip_select_n_in(cs_n), .write_strobe_n_in(we_n),
    .ext_address_in(ext_addr), .ext_data_in(ext_data)
  );

  // Clock at 40 MHz.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Presents one request; returns cycles from acceptance to strobe and strobe width.
  task automatic send(input logic [1:0] cs, input logic [21:0] a, input logic [31:0] d,
                      output int lat, output int wid);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cs <= cs;
    req_addr <= a;
    req_data <= d;
    @(negedge clk);
    while (!req_ready && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
    end
    while (&cs_n && lat < 200);
    check(32'(ext_bank), 32'h1);
    wid = 0;
    do
    begin
      @(negedge clk);
      wid++;
    end
    while (!we_n && wid < 200);
  endtask : send

  // Waits for completion, then leaves two idle cycles so the next request is not back-to-back.
  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 300);
    check(32'(done), 32'h1);
    check(32'(rw), 32'h1);
    repeat (2) @(negedge clk);
  endtask : wait_done

  task automatic t_single();
    int l, w;
    send(2'h0, 22'h10, 32'hA5A5_5A5A, l, w);
    check(32'(l), 32'h3);
    check(32'(w), 32'h2);
    wait_done();
    check(32'(u_mem.mem[32'h10]), 32'h5A5A);
    check(32'(u_mem.mem[32'h11]), 32'hA5A5);
  endtask : t_single

  task automatic t_narrow();
    int l, w;
    send(2'h2, 22'h20, 32'h4433_2211, l, w);
    check(32'(l), 32'h5);
    check(32'(w), 32'h1);
    wait_done();
    for (int k = 0; k < 4; k++)
      check(32'(u_mem.mem[32'h20 + k]), 32'(8'h11 * (k + 1)));
  endtask : t_narrow

  task automatic t_back2back();
    int l, w;
    send(2'h1, 22'h30, 32'h1357_9BDF, l, w);
    check(32'(l), 32'h4);
    check(32'(w), 32'h4);
    send(2'h1, 22'h40, 32'hCAFE_0F0F, l, w);
    check(32'(l), 32'h5);
    wait_done();
    check(32'(u_mem.mem[32'h41]), 32'hCAFE);
    send(2'h0, 22'h50, 32'h1111_2222, l, w);
    send(2'h0, 22'h60, 32'h3333_4444, l, w);
    check(32'(l), 32'h2);
    send(2'h3, 22'h70, 32'h5555_6666, l, w);
    check(32'(l), 32'h5);
    wait_done();
    check(32'(u_mem.mem[32'h60]), 32'h4444);
    check(32'(u_mem.mem[32'h71]), 32'h5555);
  endtask : t_back2back

  // Enable low for three edges in mid-strobe must stretch the strobe by exactly three cycles.
  task automatic t_freeze();
    int w;
    w = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cs <= 2'h0;
    req_addr <= 22'h80;
    req_data <= 32'h9876_FEDC;
    @(posedge clk);
    req_valid <= 1'b0;
    do
    begin
      @(negedge clk);
      w++;
    end
    while (&cs_n && w < 20);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    w = 0;
    do
    begin
      @(negedge clk);
      w++;
    end
    while (!we_n && w < 20);
    check(32'(w), 32'h2);
    wait_done();
    check(32'(u_mem.mem[32'h80]), 32'hFEDC);
    check(32'(u_mem.mem[32'h81]), 32'h9876);
  endtask : t_freeze

  // Whole run is under 150 cycles; this limit only catches a hang.
  initial
  begin
    #125000;
    mismatches++;
    print_verdict();
  end

  // Spaces: 0 S0 W1 H0 T1 wide, 1 S2 W3 H1 T0 wide, 2 S1 W0 H2 T2 narrow, 3 T3 wide.
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    req_cs = 2'h0;
    req_addr = 22'h0;
    req_bank = 2'h1;
    req_data = 32'h0;
    cfg = {16'hE000, 16'h4801, 16'h8432, 16'hA010};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(32'({cs_n, we_n, oe_n, rw, req_ready}), 32'hFF);
    t_single();
    t_narrow();
    t_back2back();
    t_freeze();
    print_verdict();
  end
endmodule : tb_top
